// ### verilog/cow_decoder.sv
// Top of the option word decoder: samples the fuse word after reset, holds
// the decoded controls, and gives the programmer a burn port over Avalon-MM.
// Assumes the fuse array drives i_fuse_word asynchronously and burns on o_burn_strobe.
`timescale 1ns/10ps
`default_nettype none

module cow_decoder
  import cow_pkg::*;
#(
  parameter int BURN_CNT = BURN_CYCLES
)
(
  input wire logic i_clock,
  input wire logic i_resetn,
  // Avalon-MM slave, programmer side only
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Fuse array
  input wire logic [WORD_W-1:0] i_fuse_word,
  output logic [WORD_W-1:0] o_burn_word,
  output logic o_burn_strobe,
  // Decoded controls
  output logic o_config_valid,
  output logic [1:0] o_osc_mode,
  output logic o_osc_power_high,
  output logic o_watchdog_enable,
  output logic o_four_clk_cycle,
  output logic o_code_protect,
  output logic o_variant_a,
  output logic [3:0] o_customer_id,
  output logic o_timer_tick
);

  //////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic cow_osc_mode_t osc_decode(input logic [WORD_W-1:0] w);
    cow_osc_mode_t m;
    m = COW_MODE_RC;
    // Frequency bit is ignored while the type bit is 0
    if (w[BIT_OSC_TYPE] && w[BIT_FREQ_SEL])
      m = COW_MODE_HXT;
    else if (w[BIT_OSC_TYPE])
      m = COW_MODE_LXT;
    return m;
  endfunction : osc_decode

  // Forces reserved bits and the frequency bit of RC words before a burn
  function automatic logic [WORD_W-1:0] sanitize(input logic [WORD_W-1:0] w);
    logic [WORD_W-1:0] s;
    s = w;
    s[BIT_RSV_HI] = 1'b1;
    s[BIT_RSV_LO] = 1'b0;
    if (!w[BIT_OSC_TYPE])
      s[BIT_FREQ_SEL] = 1'b0;
    return s;
  endfunction : sanitize

  //////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_r;
  logic rst_sync_r;
  logic rstn;

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rstn = rst_sync_r;

  //////////////////////////////////////////////////////////////////////////////
  // Fuse word capture

  logic [WORD_W-1:0] fuse_sync;
  logic [WORD_W-1:0] active_r;
  logic [2:0] settle_r;
  logic valid_r;
  logic capture_w;

  // Bits may skew across the crossing; the settle wait covers it
  cow_sync #(.WIDTH(WORD_W)) u_sync (
    .i_clock(i_clock),
    .i_resetn(rstn),
    .i_async(i_fuse_word),
    .o_sync(fuse_sync)
  );

  // Waits out the synchroniser, then captures once per reset
  assign capture_w = !valid_r && (settle_r == 3'(SETTLE_CYCLES - 1));

  always_ff @(posedge i_clock or negedge rstn)
  begin
    if (!rstn)
    begin
      settle_r <= 3'h0;
      valid_r <= 1'b0;
      active_r <= ACTIVE_RST;
    end
    else if (capture_w)
    begin
      valid_r <= 1'b1;
      active_r <= fuse_sync;
    end
    else if (!valid_r)
    begin
      settle_r <= settle_r + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoded outputs, frozen after capture

  cow_osc_mode_t mode_w;
  assign mode_w = osc_decode(fuse_sync);

  always_ff @(posedge i_clock or negedge rstn)
  begin
    if (!rstn)
    begin
      o_config_valid <= 1'b0;
      o_osc_mode <= COW_MODE_RC;
      o_osc_power_high <= 1'b0;
      o_watchdog_enable <= 1'b0;
      o_four_clk_cycle <= 1'b0;
      o_code_protect <= 1'b1;
      o_variant_a <= 1'b0;
      o_customer_id <= 4'h0;
    end
    else if (capture_w)
    begin
      o_config_valid <= 1'b1;
      o_osc_mode <= mode_w;
      o_osc_power_high <= fuse_sync[BIT_POWER_SEL];
      o_watchdog_enable <= !fuse_sync[BIT_WDT_EN_N];
      o_four_clk_cycle <= fuse_sync[BIT_FOUR_CLK];
      o_code_protect <= !fuse_sync[BIT_SECURITY_N];
      o_variant_a <= fuse_sync[BIT_VARIANT];
      o_customer_id <= fuse_sync[ID_MSB:ID_LSB];
    end
  end

  // Protection defaults on until the word is known, so nothing leaks early

  // Divider waits for the captured cycle length
  cow_cycle_div u_div (
    .i_clock(i_clock),
    .i_resetn(rstn),
    .i_enable(o_config_valid),
    .i_four_clk(o_four_clk_cycle),
    .o_tick(o_timer_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave

  logic req_w;
  logic accept_w;
  logic wr_ctrl_w;
  logic wr_word_w;
  logic start_w;
  logic done_clr_w;
  logic [31:0] rdata_w;
  logic [31:0] status_w;
  logic [31:0] ctrl_w;

  logic [WORD_W-1:0] burn_word_r;
  logic [15:0] burn_cnt_r;
  logic busy_r;
  logic done_r;
  logic refused_r;
  logic burned_r;

  assign req_w = i_avs_read || i_avs_write;
  assign accept_w = req_w && !o_avs_waitrequest;
  assign wr_word_w = accept_w && i_avs_write && (i_avs_address == OFS_BURN_WORD);
  assign wr_ctrl_w = accept_w && i_avs_write && (i_avs_address == OFS_BURN_CTRL) && i_avs_byteenable[0];
  assign start_w = wr_ctrl_w && i_avs_writedata[CTRL_START];
  assign done_clr_w = wr_ctrl_w && i_avs_writedata[CTRL_DONE];

  // Only the programmer port sees the word; no processor-side path exists
  assign status_w = {19'h0, o_config_valid, o_osc_power_high, o_watchdog_enable,
                     o_four_clk_cycle, o_code_protect, o_variant_a, 1'b0,
                     o_osc_mode, o_customer_id};
  assign ctrl_w = {28'h0, busy_r, refused_r, done_r, 1'b0};

  assign rdata_w = (i_avs_address == OFS_STATUS) ? status_w :
                   (i_avs_address == OFS_ACTIVE) ? {19'h0, active_r} :
                   (i_avs_address == OFS_BURN_WORD) ? {19'h0, burn_word_r} :
                   (i_avs_address == OFS_BURN_CTRL) ? ctrl_w : 32'h0;

  always_ff @(posedge i_clock or negedge rstn)
  begin
    if (!rstn)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0;
    end
    else
    begin
      // One wait cycle, then a single accept cycle
      o_avs_waitrequest <= !(req_w && o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest)
        o_avs_readdata <= rdata_w;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Burn sequencer

  logic [WORD_W-1:0] wmask_w;
  logic [WORD_W-1:0] burn_word_nxt;
  logic [15:0] burn_cnt_nxt;
  logic launch_w;
  logic refuse_w;
  logic finish_w;

  // Lanes 2 and 3 are ignored: the word fits in the low two lanes
  assign wmask_w = {{5{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  // One burn per reset; a second start is refused
  assign launch_w = start_w && !busy_r && !burned_r;
  assign refuse_w = start_w && (busy_r || burned_r);
  assign finish_w = busy_r && (burn_cnt_r == 16'h0);
  // Word is frozen while the fuses are being burned
  assign burn_word_nxt = (wr_word_w && !busy_r) ?
                         ((burn_word_r & ~wmask_w) | (i_avs_writedata[WORD_W-1:0] & wmask_w)) :
                         burn_word_r;
  assign burn_cnt_nxt = launch_w ? 16'(BURN_CNT - 1) :
                        (busy_r && !finish_w) ? burn_cnt_r - 16'h1 : burn_cnt_r;

  // Staged word and pulse counter
  always_ff @(posedge i_clock or negedge rstn)
  begin
    if (!rstn)
    begin
      burn_word_r <= BURN_WORD_RST;
      burn_cnt_r <= 16'h0;
    end
    else
    begin
      burn_word_r <= burn_word_nxt;
      burn_cnt_r <= burn_cnt_nxt;
    end
  end

  // Pulse starts one cycle after the accepted start
  always_ff @(posedge i_clock or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_r <= 1'b0;
      burned_r <= 1'b0;
      o_burn_word <= BURN_WORD_RST;
      o_burn_strobe <= 1'b0;
    end
    else if (launch_w)
    begin
      busy_r <= 1'b1;
      burned_r <= 1'b1;
      o_burn_word <= sanitize(burn_word_r);
      o_burn_strobe <= 1'b1;
    end
    else if (finish_w)
    begin
      busy_r <= 1'b0;
      o_burn_strobe <= 1'b0;
    end
  end

  // Set wins over a simultaneous clear
  always_ff @(posedge i_clock or negedge rstn)
  begin
    if (!rstn)
    begin
      done_r <= 1'b0;
      refused_r <= 1'b0;
    end
    else
    begin
      if (finish_w)
        done_r <= 1'b1;
      else if (done_clr_w)
        done_r <= 1'b0;
      if (refuse_w)
        refused_r <= 1'b1;
      else if (wr_ctrl_w && i_avs_writedata[CTRL_REFUSED])
        refused_r <= 1'b0;
    end
  end

endmodule : cow_decoder

`default_nettype wire

// ### verilog/cow_pkg.sv
// Constants and types for the configuration option word decoder.
// Assumes a single 40 MHz clock and an Avalon-MM slave port for the programmer.

package cow_pkg;

  localparam int WORD_W = 13;

  // Option word field positions
  localparam int BIT_OSC_TYPE = 12;
  localparam int BIT_WDT_EN_N = 11;
  localparam int BIT_FOUR_CLK = 10;
  localparam int BIT_SECURITY_N = 9;
  localparam int BIT_FREQ_SEL = 8;
  localparam int BIT_POWER_SEL = 7;
  localparam int BIT_VARIANT = 6;
  localparam int BIT_RSV_HI = 5;
  localparam int BIT_RSV_LO = 4;
  localparam int ID_MSB = 3;
  localparam int ID_LSB = 0;

  // Register byte offsets
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_ACTIVE = 4'h4;
  localparam logic [3:0] OFS_BURN_WORD = 4'h8;
  localparam logic [3:0] OFS_BURN_CTRL = 4'hC;

  // Burn control bits
  localparam int CTRL_START = 0;
  localparam int CTRL_DONE = 1;
  localparam int CTRL_REFUSED = 2;
  localparam int CTRL_BUSY = 3;

  // Values after reset
  localparam logic [WORD_W-1:0] BURN_WORD_RST = 13'h1FFF;
  localparam logic [WORD_W-1:0] ACTIVE_RST = 13'h1FFF;

  // Timing: fuse word settle after reset release, burn pulse width
  localparam int CLK_MHZ = 40;
  localparam int SETTLE_CYCLES = 4;
  localparam int BURN_TIME_NS = 1000;
  localparam int BURN_CYCLES = (BURN_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int DIV_SLOW = 4;
  localparam int DIV_FAST = 2;

  typedef enum logic [1:0] {
    COW_MODE_RC,
    COW_MODE_HXT,
    COW_MODE_LXT
  } cow_osc_mode_t;

endpackage : cow_pkg

// ### verilog/cow_sync.sv
// Two-stage synchroniser for a bus of slow levels.
// Assumes each bit changes rarely; no word coherency across bits is promised.
`timescale 1ns/10ps
`default_nettype none

module cow_sync
  import cow_pkg::*;
#(
  parameter int WIDTH = WORD_W
)
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_r <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule : cow_sync

`default_nettype wire

// ### verilog/cow_cycle_div.sv
// Instruction cycle divider: one tick every two or four oscillator periods.
// Assumes the oscillator is the module clock and the select is static once enabled.
`timescale 1ns/10ps
`default_nettype none

module cow_cycle_div
  import cow_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic i_enable,
  input wire logic i_four_clk,
  output logic o_tick
);

  logic [1:0] count_r;
  logic [1:0] count_nxt;
  logic [1:0] last_w;
  logic wrap_w;

  assign last_w = i_four_clk ? 2'(DIV_SLOW - 1) : 2'(DIV_FAST - 1);
  assign wrap_w = (count_r == last_w);
  assign count_nxt = (!i_enable || wrap_w) ? 2'h0 : count_r + 2'h1;

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      count_r <= 2'h0;
      o_tick <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      o_tick <= i_enable && wrap_w;
    end
  end

endmodule : cow_cycle_div

`default_nettype wire

// ### verification/cow_decoder_asserts.sv
// Checker for the decoded option word outputs and the burn port.
// Assumes the fuse word is steady from reset release to capture.
`timescale 1ns/10ps
`default_nettype none
module cow_decoder_asserts
  import cow_pkg::*;
#(
  parameter int BURN_CNT = BURN_CYCLES
)
(
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire logic [WORD_W-1:0] i_fuse_word,
  input wire logic [WORD_W-1:0] o_burn_word,
  input wire logic o_burn_strobe,
  input wire logic o_config_valid,
  input wire logic [1:0] o_osc_mode,
  input wire logic o_osc_power_high,
  input wire logic o_watchdog_enable,
  input wire logic o_four_clk_cycle,
  input wire logic o_code_protect,
  input wire logic o_variant_a,
  input wire logic [3:0] o_customer_id,
  input wire logic o_timer_tick
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  wire logic [WORD_W-1:0] f = i_fuse_word;
  wire logic cap = o_config_valid;
  ////////////////////////////////////////////////////////////////////////////
  property p_mode;
    $rose(cap) |-> o_osc_mode == (!f[12] ? 2'h0 : (f[8] ? 2'h1 : 2'h2));
  endproperty
  a_mode: assert property (p_mode) else $error("mode differs from word");
  property p_wdt;
    $rose(cap) |-> o_watchdog_enable == !f[11];
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog enable wrong");
  property p_four;
    $rose(cap) |-> o_four_clk_cycle == f[10];
  endproperty
  a_four: assert property (p_four) else $error("cycle length wrong");
  property p_prot;
    $rose(cap) |-> o_code_protect == !f[9];
  endproperty
  a_prot: assert property (p_prot) else $error("protection wrong");
  property p_rest;
    $rose(cap) |-> {o_osc_power_high, o_variant_a, o_customer_id} == {f[7], f[6], f[3:0]};
  endproperty
  a_rest: assert property (p_rest) else $error("power, variant or id wrong");
  property p_hold;
    cap && $past(cap) |-> $stable({o_osc_mode, o_osc_power_high, o_watchdog_enable,
      o_four_clk_cycle, o_code_protect, o_variant_a, o_customer_id});
  endproperty
  a_hold: assert property (p_hold) else $error("decoded output moved");
  property p_enc;
    o_osc_mode != 2'h3;
  endproperty
  a_enc: assert property (p_enc) else $error("illegal mode code");
  property p_tick2;
    o_timer_tick && !o_four_clk_cycle |=> !o_timer_tick ##1 o_timer_tick;
  endproperty
  a_tick2: assert property (p_tick2) else $error("tick period not 2");
  property p_tick4;
    o_timer_tick && o_four_clk_cycle |=> !o_timer_tick [*3] ##1 o_timer_tick;
  endproperty
  a_tick4: assert property (p_tick4) else $error("tick period not 4");
  property p_burn;
    o_burn_strobe |-> o_burn_word[5] && !o_burn_word[4] && (o_burn_word[12] || !o_burn_word[8]);
  endproperty
  a_burn: assert property (p_burn) else $error("burn word not sanitised");
  c_cap: cover property ($rose(cap));
  c_burn: cover property ($rose(o_burn_strobe));
  c_four: cover property (o_timer_tick && o_four_clk_cycle);
endmodule : cow_decoder_asserts
bind cow_decoder cow_decoder_asserts #(.BURN_CNT(BURN_CNT)) cow_decoder_asserts_inst (.i_clock, .i_resetn,
  .i_fuse_word, .o_burn_word, .o_burn_strobe, .o_config_valid, .o_osc_mode, .o_osc_power_high,
  .o_watchdog_enable, .o_four_clk_cycle, .o_code_protect, .o_variant_a, .o_customer_id, .o_timer_tick);
`default_nettype wire

// ### verification/cow_fuse_model.sv
// Fuse array model: preset on load, burning only clears cells.
// Assumes load is pulsed while the decoder is in reset.
`timescale 1ns/10ps
`default_nettype none
module cow_fuse_model
  import cow_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_load,
  input wire logic [WORD_W-1:0] i_preset,
  input wire logic [WORD_W-1:0] i_burn_word,
  input wire logic i_burn_strobe,
  output logic [WORD_W-1:0] o_fuse_word
);
  always_ff @(posedge i_clock)
  begin
    if (i_load)
      o_fuse_word <= i_preset;
    else if (i_burn_strobe)
      o_fuse_word <= o_fuse_word & i_burn_word; // OTP: a blown cell never returns to 1
  end
endmodule : cow_fuse_model
`default_nettype wire

// ### verification/cow_decoder_bench.sv
// Bench for the option word decoder: table of words, then burn cases.
// Assumes the fuse model as far side and a 40 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module cow_decoder_bench
  import cow_pkg::*;
;
  logic clk, rstn, rd, wr, load, burn_s, valid, pwr, wdt, four, prot, var_a, tick, wait_r;
  logic [3:0] addr, id;
  logic [31:0] wdata, rdata, q;
  logic [12:0] preset, fuse, bword, w;
  logic [1:0] mode;
  logic [11:0] e;
  int error_cnt, n_checks, n;
  // Word beside its mode; crystal class follows frequency choice
  logic [14:0] rows [6] = '{{13'h04A5, 2'h0}, {13'h0B6A, 2'h0}, {13'h112F, 2'h1},
    {13'h1FE3, 2'h1}, {13'h1426, 2'h2}, {13'h10A0, 2'h2}};
  ////////////////////////////////////////////////////////////////////////////
  cow_fuse_model cow_fuse_model_inst (.i_clock(clk), .i_load(load), .i_preset(preset),
    .i_burn_word(bword), .i_burn_strobe(burn_s), .o_fuse_word(fuse));
  cow_decoder #(.BURN_CNT(3)) cow_decoder_inst (.i_clock(clk), .i_resetn(rstn), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r), .i_fuse_word(fuse), .o_burn_word(bword),
    .o_burn_strobe(burn_s), .o_config_valid(valid), .o_osc_mode(mode), .o_osc_power_high(pwr),
    .o_watchdog_enable(wdt), .o_four_clk_cycle(four), .o_code_protect(prot), .o_variant_a(var_a),
    .o_customer_id(id), .o_timer_tick(tick));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w_en, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w_en;
    wr <= w_en;
    addr <= a;
    wdata <= d;
    do
    begin
      @(posedge clk);
    end
    while (wait_r !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  // Reset is held ten cycles, then we wait for capture
  task automatic rst(input logic ld, input logic [12:0] pw);
    @(posedge clk);
    rstn <= 1'b0;
    load <= ld;
    preset <= pw;
    @(posedge clk);
    load <= 1'b0;
    repeat (9) @(posedge clk);
    rstn <= 1'b1;
    while (valid !== 1'b1)
    begin
      @(posedge clk);
    end
  endtask : rst
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial
  begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rd, wr, load, rstn} = 4'h0;
    addr = 4'h0;
    wdata = 32'h0;
    preset = 13'h1FFF;
    foreach (rows[i])
    begin
      w = rows[i][14:2];
      rst(1'b1, w);
      e = {1'b1, rows[i][1:0], w[7], !w[11], w[10], !w[9], w[6], w[3:0]};
      chk({valid, mode, pwr, wdt, four, prot, var_a, id}, e);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(q, {19'h0, e[11], e[8:4], 1'b0, e[10:9], e[3:0]});
      bus(1'b0, OFS_ACTIVE, 32'h0);
      chk(q, {19'h0, w});
      n = 0;
      repeat (8)
      begin
        @(posedge clk);
        if (tick === 1'b1)
          n++;
      end
      chk(n, 8 / (w[10] ? DIV_SLOW : DIV_FAST));
    end
    // Awkward cases: illegal burn word, second start, read-only and unmapped places
    bus(1'b0, OFS_BURN_WORD, 32'h0);
    chk(q, 32'h1FFF);
    bus(1'b1, OFS_BURN_WORD, 32'h0FFF);
    bus(1'b1, OFS_BURN_CTRL, 32'h1);
    while (burn_s !== 1'b1)
    begin
      @(posedge clk);
    end
    chk(bword, 13'h0EEF);
    n = 0;
    while (burn_s === 1'b1)
    begin
      @(posedge clk);
      n++;
    end
    chk(n, 3);
    bus(1'b0, OFS_BURN_CTRL, 32'h0);
    chk(q, 32'h2);
    bus(1'b1, OFS_BURN_CTRL, 32'h1);
    bus(1'b0, OFS_BURN_CTRL, 32'h0);
    chk(q, 32'h6);
    bus(1'b1, OFS_ACTIVE, 32'h0);
    bus(1'b0, OFS_ACTIVE, 32'h0);
    chk(q, 32'h10A0);
    bus(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    chk(mode, 2'h2);
    // New word only takes effect after the next reset
    rst(1'b0, 13'h0);
    bus(1'b0, OFS_ACTIVE, 32'h0);
    chk(q, 32'h00A0);
    chk(mode, 2'h0);
    give_verdict();
  end
endmodule : cow_decoder_bench
`default_nettype wire
